// ==== design/pump_lead_lag_staging.v ====
// lead-lag staging: switches up to four lag motor relays from the
// output frequency and feedback, and orders a ramp after each timed start or stop
// assumes aclk at 25 MHz, synchronous inputs, an AXI4-Lite master
//
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`include "staging_regs.vh"
`default_nettype none

module pump_lead_lag_staging #(
	parameter TICK_CYCLES = `DELAY_UNIT_NS / `CLK_PERIOD_NS
) (
	input wire aclk,
	input wire aresetn,
	input wire [11:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [11:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire [15:0] out_freq,
	input wire [15:0] feedback,
	output reg [3:0] aux_relay_ff,
	output reg aux1_staging_ff,
	output reg lead_pid_ff,
	output reg ramp_go_ff,
	output reg ramp_up_ff,
	output reg [15:0] ramp_freq_ff,
	output reg [15:0] ramp_time_ff
);

	localparam [1:0] KIND_NONE = 2'h0;
	localparam [1:0] KIND_RW = 2'h1;
	localparam [1:0] KIND_RO = 2'h2;
	localparam [31:0] TICK_LAST = TICK_CYCLES - 1;

	wire [16*`NUM_CFG-1:0] cfg_flat;

	function [1:0] reg_kind;
		input [11:0] addr;
		reg [11:0] a;
		begin
			a = {addr[11:2], 2'h0};
			if (a <= `OFF_LAST_RW) begin
				reg_kind = KIND_RW;
			end else if (a == `OFF_STATUS) begin
				reg_kind = KIND_RO;
			end else if (a == `OFF_LEVELS) begin
				reg_kind = KIND_RO;
			end else begin
				reg_kind = KIND_NONE;
			end
		end
	endfunction

	function [15:0] rst_val;
		input integer k;
		begin
			if (k == 0) begin
				rst_val = `RST_CTRL;
			end else if (k <= 4) begin
				rst_val = `RST_START_THR;
			end else if (k <= 8) begin
				rst_val = `RST_STOP_THR;
			end else begin
				case (k)
				9: rst_val = `RST_START_DLY;
				10: rst_val = `RST_STOP_DLY;
				11: rst_val = `RST_ACC_TIME;
				12: rst_val = `RST_ACC_FREQ;
				13: rst_val = `RST_DEC_TIME;
				14: rst_val = `RST_DEC_FREQ;
				15: rst_val = `RST_MARGIN;
				16: rst_val = `RST_MARGIN;
				17: rst_val = `RST_SETPOINT;
				default: rst_val = `RST_FB_RANGE;
				endcase
			end
		end
	endfunction

	function [15:0] cfg_word;
		input [11:0] off;
		input [1:0] k;
		reg [4:0] idx;
		begin
			idx = off[6:2] + {3'h0, k};
			cfg_word = cfg_flat[16*idx +: 16];
		end
	endfunction

	// write channel: address and data are caught independently
	reg aw_hold_ff;
	reg w_hold_ff;
	reg [11:0] aw_addr_ff;
	reg [31:0] w_data_ff;
	reg [3:0] w_strb_ff;
	wire aw_take = s_axi_awvalid & s_axi_awready;
	wire w_take = s_axi_wvalid & s_axi_wready;
	wire wr_commit = aw_hold_ff & w_hold_ff & ~s_axi_bvalid;
	wire [1:0] wr_kind = reg_kind(aw_addr_ff);
	wire wr_ok = wr_commit & (wr_kind == KIND_RW);
	wire nxt_aw_hold = aw_take | (aw_hold_ff & ~wr_commit);
	wire nxt_w_hold = w_take | (w_hold_ff & ~wr_commit);
	wire nxt_bvalid = wr_commit | (s_axi_bvalid & ~s_axi_bready);
	wire [15:0] old_word = cfg_word(aw_addr_ff, 2'h0);
	wire [15:0] merged = {
		w_strb_ff[1] ? w_data_ff[15:8] : old_word[15:8],
		w_strb_ff[0] ? w_data_ff[7:0] : old_word[7:0]};

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_ff <= 1'b0;
			w_hold_ff <= 1'b0;
			aw_addr_ff <= 12'h000;
			w_data_ff <= 32'h00000000;
			w_strb_ff <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else begin
			aw_hold_ff <= nxt_aw_hold;
			w_hold_ff <= nxt_w_hold;
			if (aw_take) begin
				aw_addr_ff <= s_axi_awaddr;
			end
			if (w_take) begin
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
			end
			// ready drops while a response is pending: one write at a time
			s_axi_awready <= ~nxt_aw_hold & ~nxt_bvalid;
			s_axi_wready <= ~nxt_w_hold & ~nxt_bvalid;
			s_axi_bvalid <= nxt_bvalid;
			if (wr_commit) begin
				s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
			end
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < `NUM_CFG; gi = gi + 1) begin : g_cfg
			localparam [4:0] K = gi;
			reg [15:0] word_ff;
			always @(posedge aclk) begin
				if (!aresetn) begin
					word_ff <= rst_val(gi);
				end else if (wr_ok && aw_addr_ff[6:2] == K) begin
					word_ff <= merged;
				end
			end
			assign cfg_flat[16*gi +: 16] = word_ff;
		end
	endgenerate

	// configuration fields
	wire [15:0] ctrl = cfg_word(`OFF_CTRL, 2'h0);
	wire stage_en = ctrl[`CTRL_EN_BIT];
	wire pid_en = ctrl[`CTRL_PID_BIT];
	wire [2:0] lag_raw = ctrl[`CTRL_LAG_MSB:`CTRL_LAG_LSB];
	// counts above four are held at four
	wire [2:0] lag_cnt = (lag_raw > `LAG_MAX) ? `LAG_MAX : lag_raw;
	wire [15:0] start_dly = cfg_word(`OFF_START_DLY, 2'h0);
	wire [15:0] stop_dly = cfg_word(`OFF_STOP_DLY, 2'h0);
	wire [15:0] start_mrg = cfg_word(`OFF_START_MARGIN, 2'h0);
	wire [15:0] stop_mrg = cfg_word(`OFF_STOP_MARGIN, 2'h0);
	wire [15:0] setpoint = cfg_word(`OFF_SETPOINT, 2'h0);
	wire [15:0] fb_range = cfg_word(`OFF_FB_RANGE, 2'h0);

	// feedback levels, registered to keep the divider off the
	// decision path; they lag setting changes by one cycle
	reg [15:0] start_lvl_ff;
	reg [15:0] stop_lvl_ff;
	wire [31:0] start_prod = fb_range * start_mrg;
	wire [31:0] stop_prod = fb_range * stop_mrg;
	wire [31:0] start_off = start_prod / `PCT_SCALE;
	wire [31:0] stop_off = stop_prod / `PCT_SCALE;
	wire [31:0] stop_sum = {16'h0000, setpoint} + stop_off;

	always @(posedge aclk) begin
		if (!aresetn) begin
			start_lvl_ff <= 16'h0000;
			stop_lvl_ff <= 16'h0000;
		end else begin
			if (start_off > {16'h0000, setpoint}) begin
				start_lvl_ff <= 16'h0000;
			end else begin
				start_lvl_ff <= setpoint - start_off[15:0];
			end
			if (stop_sum[31:16] != 16'h0000) begin
				stop_lvl_ff <= 16'hffff;
			end else begin
				stop_lvl_ff <= stop_sum[15:0];
			end
		end
	end

	// running stages are always contiguous from aux one upward
	reg [2:0] stage_n;
	always @* begin
		case (1'b1)
		aux_relay_ff[3]: stage_n = 3'h4;
		aux_relay_ff[2]: stage_n = 3'h3;
		aux_relay_ff[1]: stage_n = 3'h2;
		aux_relay_ff[0]: stage_n = 3'h1;
		default: stage_n = 3'h0;
		endcase
	end

	wire [1:0] up_sel = stage_n[1:0];
	wire [1:0] dn_sel = stage_n[1:0] - 2'h1;
	wire [15:0] start_thr = cfg_word(`OFF_START_THR, up_sel);
	wire [15:0] stop_thr = cfg_word(`OFF_STOP_THR, dn_sel);

	// a zero margin removes its own feedback term; with both zero or
	// PID off only frequency and delay decide
	wire fb_start_ok = ~pid_en | (start_mrg == 16'h0000) |
		(feedback < start_lvl_ff);
	wire fb_stop_ok = ~pid_en | (stop_mrg == 16'h0000) |
		(feedback > stop_lvl_ff);

	// next stage only above all running ones, so aux n needs 1..n-1
	wire start_cond = stage_en & (stage_n < lag_cnt) &
		(out_freq > start_thr) & fb_start_ok;
	// only the highest running stage may stop
	wire stop_cond = stage_en & (stage_n != 3'h0) &
		(out_freq < stop_thr) & fb_stop_ok;

	// 0.1 s tick shared by both delay timers
	reg [31:0] tick_cnt_ff;
	wire tick = (tick_cnt_ff == TICK_LAST);

	always @(posedge aclk) begin
		if (!aresetn) begin
			tick_cnt_ff <= 32'h00000000;
		end else if (tick) begin
			tick_cnt_ff <= 32'h00000000;
		end else begin
			tick_cnt_ff <= tick_cnt_ff + 32'h00000001;
		end
	end

	reg [15:0] start_t_ff;
	reg [15:0] stop_t_ff;
	wire start_fire = start_cond & (start_t_ff >= start_dly);
	wire stop_fire = ~start_fire & stop_cond &
		(stop_t_ff >= stop_dly);
	wire stage_chg = start_fire | stop_fire;

	// the tick phase is free running, so a delay can run up to one
	// tick short; the trade keeps one prescaler for both timers
	always @(posedge aclk) begin
		if (!aresetn) begin
			start_t_ff <= 16'h0000;
			stop_t_ff <= 16'h0000;
		end else begin
			if (!start_cond || stage_chg) begin
				start_t_ff <= 16'h0000;
			end else if (tick && start_t_ff < start_dly) begin
				start_t_ff <= start_t_ff + 16'h0001;
			end
			if (!stop_cond || stage_chg) begin
				stop_t_ff <= 16'h0000;
			end else if (tick && stop_t_ff < stop_dly) begin
				stop_t_ff <= stop_t_ff + 16'h0001;
			end
		end
	end

	// stages the current settings still allow
	reg [3:0] allow;
	always @* begin
		case (lag_cnt)
		3'h0: allow = 4'h0;
		3'h1: allow = 4'h1;
		3'h2: allow = 4'h3;
		3'h3: allow = 4'h7;
		default: allow = 4'hf;
		endcase
		if (!stage_en) begin
			allow = 4'h0;
		end
	end

	reg [3:0] nxt_relay;
	always @* begin
		nxt_relay = aux_relay_ff;
		if (start_fire) begin
			nxt_relay = {aux_relay_ff[2:0], 1'b1};
		end else if (stop_fire) begin
			nxt_relay = {1'b0, aux_relay_ff[3:1]};
		end
		nxt_relay = nxt_relay & allow;
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			aux_relay_ff <= 4'h0;
			aux1_staging_ff <= 1'b0;
			lead_pid_ff <= 1'b0;
			ramp_go_ff <= 1'b0;
			ramp_up_ff <= 1'b0;
			ramp_freq_ff <= 16'h0000;
			ramp_time_ff <= 16'h0000;
		end else begin
			aux_relay_ff <= nxt_relay;
			aux1_staging_ff <= stage_en;
			lead_pid_ff <= stage_en & pid_en;
			ramp_go_ff <= stage_chg;
			if (start_fire) begin
				ramp_up_ff <= 1'b0;
				ramp_freq_ff <= cfg_word(`OFF_DEC_FREQ, 2'h0);
				ramp_time_ff <= cfg_word(`OFF_DEC_TIME, 2'h0);
			end else if (stop_fire) begin
				ramp_up_ff <= 1'b1;
				ramp_freq_ff <= cfg_word(`OFF_ACC_FREQ, 2'h0);
				ramp_time_ff <= cfg_word(`OFF_ACC_TIME, 2'h0);
			end
		end
	end

	// read channel
	wire ar_take = s_axi_arvalid & s_axi_arready;
	wire nxt_rvalid = ar_take | (s_axi_rvalid & ~s_axi_rready);
	wire [1:0] rd_kind = reg_kind(s_axi_araddr);
	wire [31:0] status_word = {21'h000000, ramp_up_ff, stop_cond,
		start_cond, 1'b0, stage_n, aux_relay_ff};
	reg [31:0] rd_word;

	always @* begin
		rd_word = 32'h00000000;
		if (rd_kind == KIND_RW) begin
			rd_word = {16'h0000, cfg_word(s_axi_araddr, 2'h0)};
		end else if ({s_axi_araddr[11:2], 2'h0} == `OFF_STATUS) begin
			rd_word = status_word;
		end else if ({s_axi_araddr[11:2], 2'h0} == `OFF_LEVELS) begin
			rd_word = {stop_lvl_ff, start_lvl_ff};
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
		end else begin
			s_axi_arready <= ~nxt_rvalid;
			s_axi_rvalid <= nxt_rvalid;
			if (ar_take) begin
				s_axi_rdata <= rd_word;
				if (rd_kind == KIND_NONE) begin
					s_axi_rresp <= `RESP_SLVERR;
				end else begin
					s_axi_rresp <= `RESP_OKAY;
				end
			end
		end
	end

endmodule

`default_nettype wire

// ==== design/staging_regs.vh ====
// register map, field positions, reset values and timing figures
// for the lead-lag staging block; included by its bare name
`ifndef STAGING_REGS_VH
`define STAGING_REGS_VH

// byte offsets on the AXI4-Lite register bus
`define OFF_CTRL 12'h000
`define OFF_START_THR 12'h004
`define OFF_STOP_THR 12'h014
`define OFF_START_DLY 12'h024
`define OFF_STOP_DLY 12'h028
`define OFF_ACC_TIME 12'h02c
`define OFF_ACC_FREQ 12'h030
`define OFF_DEC_TIME 12'h034
`define OFF_DEC_FREQ 12'h038
`define OFF_START_MARGIN 12'h03c
`define OFF_STOP_MARGIN 12'h040
`define OFF_SETPOINT 12'h044
`define OFF_FB_RANGE 12'h048
`define OFF_STATUS 12'h04c
`define OFF_LEVELS 12'h050
`define OFF_LAST_RW 12'h048
`define NUM_CFG 19

// control register fields
`define CTRL_EN_BIT 0
`define CTRL_PID_BIT 1
`define CTRL_LAG_LSB 2
`define CTRL_LAG_MSB 4
`define LAG_MAX 3'h4

// reset values
`define RST_CTRL 16'h0000
`define RST_START_THR 16'h170c
`define RST_STOP_THR 16'h0fa0
`define RST_START_DLY 16'h0032
`define RST_STOP_DLY 16'h0014
`define RST_ACC_TIME 16'h0014
`define RST_ACC_FREQ 16'h0bb8
`define RST_DEC_TIME 16'h0064
`define RST_DEC_FREQ 16'h170c
`define RST_MARGIN 16'h0014
`define RST_SETPOINT 16'h0000
`define RST_FB_RANGE 16'h0000

// timing: delays count in units of 0.1 s
`define CLK_PERIOD_NS 40
`define DELAY_UNIT_NS 100000000
// margins are in 0.1 %, so percent over 100 becomes tenths over 1000
`define PCT_SCALE 32'h000003e8

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== verification/staging_checker.sv ====
// checker: relay staging order, ramp pulses and bus answers
// assumes binding to pump_lead_lag_staging, one clock domain
`default_nettype none
module staging_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic [3:0] aux_relay_ff,
	input wire logic aux1_staging_ff,
	input wire logic lead_pid_ff,
	input wire logic ramp_go_ff,
	input wire logic ramp_up_ff
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking dc @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence both_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence stage_up;
		ramp_go_ff && aux_relay_ff > $past(aux_relay_ff);
	endsequence
	sequence stage_down;
		ramp_go_ff && aux_relay_ff < $past(aux_relay_ff);
	endsequence
	a_fill_order: assert property (aux_relay_ff inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hf})
		else $error("relays not filled from aux one up");
	a_ramp_on_change: assert property (ramp_go_ff |-> aux_relay_ff != $past(aux_relay_ff))
		else $error("ramp pulse without a stage change");
	a_step_up_one: assert property (aux_relay_ff > $past(aux_relay_ff) |->
		aux_relay_ff == (($past(aux_relay_ff) << 1) | 4'h1) && ramp_go_ff)
		else $error("start was not one stage with a ramp");
	a_start_ramp_down: assert property (stage_up |-> !ramp_up_ff)
		else $error("start did not order a deceleration");
	a_stop_ramp_up: assert property (stage_down |-> ramp_up_ff)
		else $error("stop did not order an acceleration");
	a_pid_needs_stage: assert property (lead_pid_ff |-> aux1_staging_ff)
		else $error("lead on pid while staging is off");
	a_off_drops_relays: assert property (!aux1_staging_ff [*3] |-> aux_relay_ff == 4'h0)
		else $error("relay held while staging is off");
	a_write_answer: assert property (both_taken |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
endmodule
bind pump_lead_lag_staging staging_checker chk (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .aux_relay_ff, .aux1_staging_ff, .lead_pid_ff,
	.ramp_go_ff, .ramp_up_ff);
`default_nettype wire

// ==== verification/lag_starters.sv ====
// lag starter bank: a contactor closes one clock after its relay
// assumes relay outputs are registered levels, high = run
`default_nettype none
module lag_starters (
	input wire logic aclk,
	input wire logic [3:0] relay,
	output var logic [3:0] running
);
	timeunit 1ns;
	timeprecision 1ns;
	always @(posedge aclk) begin
		running <= relay;
	end
endmodule
`default_nettype wire

// ==== verification/pump_lead_lag_staging_test.sv ====
// bench for the lead-lag staging block: bus, relays, margins
// assumes TICK_CYCLES of 4 and a 25 MHz aclk
`include "staging_regs.vh"
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_count++; \
	$display("[FAIL] t=%0t got %h exp %h", $time, a, e); end end
module pump_lead_lag_staging_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk = 0, aresetn = 0, hi = 0;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic [31:0] s_axi_wdata = 0, seed = 13;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [15:0] out_freq = 0, feedback = 0, fb_lo = 0, fb_span = 1;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire ramp_go_ff, ramp_up_ff, aux1_staging_ff, lead_pid_ff;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [3:0] aux_relay_ff, running;
	wire [15:0] ramp_freq_ff, ramp_time_ff;
	int err_count = 0, num_checks = 0, pulses = 0, p0;
	pump_lead_lag_staging #(.TICK_CYCLES(4)) dut (.aclk, .aresetn,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .out_freq,
		.feedback, .aux_relay_ff, .aux1_staging_ff, .lead_pid_ff, .ramp_go_ff,
		.ramp_up_ff, .ramp_freq_ff, .ramp_time_ff);
	lag_starters partner (.aclk, .relay(aux_relay_ff), .running);
	always #20 aclk = ~aclk;
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	function automatic logic [32:0] ramp_exp(input logic up);
		return up ? {1'b1, 16'h0bb8, 16'h0014} : {1'b0, 16'h170c, 16'h0064};
	endfunction
	function automatic logic [31:0] lv(input int sp, input int rg, input int m);
		return {16'(sp + rg * m / 1000), 16'(sp - rg * m / 1000)};
	endfunction
	// random speed stays strictly inside the start or stop band
	always @(posedge aclk) begin
		seed <= xorshift(seed);
		out_freq <= hi ? 16'd5901 + seed[9:0] : {5'h0, seed[10:0]};
		feedback <= fb_lo + seed[15:0] % fb_span;
		if (ramp_go_ff) pulses <= pulses + 1;
	end
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic bus(input bit w, input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] er);
		int n;
		bit pa, pw, done;
		logic [31:0] got;
		logic [1:0] rsp;
		pa = 1;
		pw = w;
		done = 0;
		n = 0;
		if (w) begin
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1;
			s_axi_wvalid <= 1;
			s_axi_bready <= 1;
		end else begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1;
			s_axi_rready <= 1;
		end
		while (!done && n < 50) begin
			@(negedge aclk);
			if (!pa && !pw && (w ? s_axi_bvalid : s_axi_rvalid)) begin
				done = 1;
				rsp = w ? s_axi_bresp : s_axi_rresp;
				got = s_axi_rdata;
			end
			if (w ? s_axi_awready : s_axi_arready) pa = 0;
			if (s_axi_wready) pw = 0;
			@(posedge aclk);
			n++;
			if (w) begin
				s_axi_awvalid <= pa;
				s_axi_wvalid <= pw;
				s_axi_bready <= !done;
			end else begin
				s_axi_arvalid <= pa;
				s_axi_rready <= !done;
			end
		end
		if (!done) begin
			err_count++;
			give_verdict;
		end
		// idle edge: a following call must not re-raise a ready just dropped
		@(posedge aclk);
		`CHK(rsp, er)
		if (!w) `CHK(got, d)
	endtask
	task automatic wait_relay(input logic [3:0] e, input int lim);
		int n;
		n = 0;
		do begin
			@(negedge aclk);
			n++;
		end while (aux_relay_ff !== e && n < lim);
		`CHK(aux_relay_ff, e)
		@(posedge aclk);
	endtask
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		bus(0, `OFF_CTRL, 0, `RESP_OKAY);
		bus(0, 12'h008, 32'h170c, `RESP_OKAY);
		bus(0, 12'h01c, 32'h0fa0, `RESP_OKAY);
		bus(0, `OFF_START_DLY, 32'h32, `RESP_OKAY);
		bus(0, `OFF_ACC_FREQ, 32'h0bb8, `RESP_OKAY);
		bus(0, 12'h100, 0, `RESP_SLVERR);
		bus(1, `OFF_STATUS, 1, `RESP_SLVERR);
		bus(1, `OFF_START_DLY, 2, `RESP_OKAY);
		bus(1, `OFF_STOP_DLY, 1, `RESP_OKAY);
		hi <= 1;
		bus(1, `OFF_CTRL, 32'h09, `RESP_OKAY);
		wait_relay(4'h1, 100);
		`CHK({ramp_up_ff, ramp_freq_ff, ramp_time_ff}, ramp_exp(0))
		`CHK(aux1_staging_ff, 1'b1)
		wait_relay(4'h3, 100);
		repeat (100) @(posedge aclk);
		wait_relay(4'h3, 1);
		hi <= 0;
		wait_relay(4'h1, 100);
		`CHK({ramp_up_ff, ramp_freq_ff, ramp_time_ff}, ramp_exp(1))
		wait_relay(4'h0, 100);
		hi <= 1;
		bus(1, `OFF_CTRL, 32'h11, `RESP_OKAY);
		wait_relay(4'hf, 400);
		// the pulse of the last start is only counted at this edge
		@(negedge aclk);
		p0 = pulses;
		@(posedge aclk);
		bus(1, `OFF_CTRL, 32'h0d, `RESP_OKAY);
		wait_relay(4'h7, 10);
		bus(1, `OFF_CTRL, 0, `RESP_OKAY);
		wait_relay(4'h0, 10);
		`CHK(pulses, p0)
		bus(1, `OFF_SETPOINT, 32'h03e8, `RESP_OKAY);
		bus(1, `OFF_FB_RANGE, 32'h03e8, `RESP_OKAY);
		bus(0, `OFF_LEVELS, lv(1000, 1000, 20), `RESP_OKAY);
		fb_lo <= 990;
		fb_span <= 50;
		bus(1, `OFF_CTRL, 32'h07, `RESP_OKAY);
		`CHK(lead_pid_ff, 1'b1)
		repeat (100) @(posedge aclk);
		wait_relay(4'h0, 1);
		fb_lo <= 900;
		fb_span <= 79;
		wait_relay(4'h1, 100);
		hi <= 0;
		fb_lo <= 1000;
		fb_span <= 20;
		repeat (100) @(posedge aclk);
		wait_relay(4'h1, 1);
		fb_lo <= 1021;
		fb_span <= 100;
		wait_relay(4'h0, 100);
		bus(1, `OFF_START_MARGIN, 0, `RESP_OKAY);
		bus(1, `OFF_STOP_MARGIN, 0, `RESP_OKAY);
		fb_lo <= 16'h2000;
		hi <= 1;
		wait_relay(4'h1, 100);
		// starters follow the relays one clock late
		@(negedge aclk);
		`CHK(running, aux_relay_ff)
		give_verdict;
	end
endmodule
`default_nettype wire
